// [rtl/mst_params.svh]
// Register offsets, field positions, reset values and limits of the mailbox status and timer block
`ifndef MST_PARAMS_SVH
`define MST_PARAMS_SVH

// Word offsets on the register port
`define MST_OFS_CMD_WORD      4'h0
`define MST_OFS_CMD_FINAL     4'h1
`define MST_OFS_CMD_SPACE     4'h2
`define MST_OFS_RSP_DATA      4'h5
`define MST_OFS_RSP_LEVEL     4'h6
`define MST_OFS_IRQ_ENABLE    4'h7
`define MST_OFS_EVENT_FLAGS   4'h8
`define MST_OFS_CMD_WATCHDOG  4'h9
`define MST_OFS_BP_WATCHDOG   4'ha

// Event flag bit positions and masks
`define MST_EV_DATA_VALID     0
`define MST_EV_CMD_NOT_FULL   1
`define MST_EV_LEN_MISMATCH   3
`define MST_EV_EOP_TIMEOUT    4
`define MST_EV_BP_TIMEOUT     5
`define MST_EV_MEM_TIMEOUT    6
`define MST_EV_RECOVERY       7
`define MST_EV_FULL_WRITE     8
`define MST_EV_EMPTY_READ     9
`define MST_EV_USED_MASK      10'h3fb
`define MST_EV_ERROR_MASK     10'h378

// Watchdog register layout and reset value
`define MST_WD_EN_BIT         31
`define MST_WD_PERIOD_MSB     30
`define MST_WD_RESET_VALUE    32'h07ff_ffff

// Header length field and response level layout
`define MST_HDR_LEN_MSB       22
`define MST_HDR_LEN_LSB       12
`define MST_RSP_EOP_BIT       1
`define MST_RSP_SOP_BIT       0
`define MST_RSP_LEVEL_LSB     2

`endif

// [rtl/mst_pkg.sv]
// Shared types of the mailbox status and timer block
package mst_pkg;

	typedef logic [31:0] mst_word_t;

	typedef enum logic {
		WD_IDLE,
		WD_COUNT
	} mst_wd_state_e;

endpackage

// [rtl/mst_sync2.sv]
// Two-stage synchroniser for levels arriving from outside the core clock domain
`timescale 1ns/10ps
module mst_sync2 #(
	parameter int WIDTH = 1
) (
	input  wire logic             sys_clk,
	input  wire logic             srst,
	input  wire logic             ce,
	input  wire logic [WIDTH-1:0] asyncIn,
	output logic      [WIDTH-1:0] syncOut
);

	logic [WIDTH-1:0] stage1_q;

	////////////////////////////////////////////////////////////////////////////////
	// First stage feeds only the second stage, to keep metastability contained
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			stage1_q <= '0;
			syncOut  <= '0;
		end
		else if (ce)
		begin
			stage1_q <= asyncIn;
			syncOut  <= stage1_q;
		end
	end

endmodule

// [rtl/mst_watchdog.sv]
// Programmable down-counting watchdog, armed by a start event and cancelled by a stop event
`timescale 1ns/10ps
module mst_watchdog
	import mst_pkg::*;
#(
	parameter int PERIOD_W = 31
) (
	input  wire logic                sys_clk,
	input  wire logic                srst,
	input  wire logic                ce,
	input  wire logic                enable,
	input  wire logic [PERIOD_W-1:0] period,
	input  wire logic                start,
	input  wire logic                stop,
	output logic                     running,
	output logic                     expire
);

	mst_wd_state_e         state_q;
	logic [PERIOD_W-1:0]   count_q;

	assign running = (state_q == WD_COUNT);
	// Expiry is a one-cycle pulse, only while the clock enable lets state move
	assign expire  = ce && running && enable && !stop && (count_q == '0);

	////////////////////////////////////////////////////////////////////////////////
	// Load on start, count down each cycle, return to idle on stop or expiry
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			state_q <= WD_IDLE;
			count_q <= '0;
		end
		else if (ce)
		begin
			case (state_q)
				WD_IDLE:
				begin
					if (enable && start && !stop)
					begin
						state_q <= WD_COUNT;
						count_q <= period;
					end
				end
				WD_COUNT:
				begin
					if (stop || !enable)
					begin
						state_q <= WD_IDLE; // Reload happens on the next start
					end
					else if (count_q == '0)
					begin
						state_q <= WD_IDLE;
					end
					else
					begin
						count_q <= count_q - 1'b1;
					end
				end
				default:
				begin
					state_q <= WD_IDLE;
				end
			endcase
		end
	end

endmodule

// [rtl/mst_status_timers.sv]
// Mailbox status flags, interrupt gating and command and backpressure watchdogs
// Contract
// - Any error flushes all pending responses until reset
// - Bit 9 set on empty response read
// - Bit 8 set on full command write
// - Bit 7 shows crypto recovery in progress
// - Bit 6 set on crypto memory timeout
// - Bit 5 set on backpressure timer expiry
// - Bit 4 set on end-of-packet timer expiry
// - Bit 3 set on header length mismatch
// - Bit 1 live while command space remains
// - Bit 0 live while response data available
// - Flags always visible; enables gate interrupt only
// - Command timer: enable bit 31, period 30:0
// - Command timer starts on first word write
// - Final word write stops timer; next first word write reloads it
// - Command expiry sets bit 4, clears enable
// - Backpressure timer counts manager-ready-low cycles
// - Backpressure expiry sets bit 5, clears enable
// - Reset restores timer registers to defaults
`timescale 1ns/10ps
`include "mst_params.svh"
module mst_status_timers
	import mst_pkg::*;
#(
	parameter int LEVEL_W  = 11,
	parameter int PERIOD_W = 31
) (
	input  wire logic               sys_clk,
	input  wire logic               srst,
	input  wire logic               ce,
	input  wire logic [3:0]         busAddr,
	input  wire logic               busWrite,
	input  wire logic               busRead,
	input  wire logic [31:0]        busWriteData,
	output mst_word_t               busReadData,
	output logic                    busReadValid,
	input  wire logic               cmdFifoFull,
	input  wire logic [LEVEL_W-1:0] cmdFifoSpace,
	input  wire logic               rspFifoEmpty,
	input  wire logic [LEVEL_W-1:0] rspFifoLevel,
	input  wire logic               rspSop,
	input  wire logic               rspEop,
	input  wire logic [31:0]        rspData,
	input  wire logic               mgrReady,
	input  wire logic               cryptoMemTimeoutPin,
	input  wire logic               cryptoRecoveryPin,
	output logic                    cmdPush,
	output mst_word_t               cmdWord,
	output logic                    cmdLast,
	output logic                    rspPop,
	output logic                    rspFlush,
	output logic                    irq
);

	logic [9:0]          sticky_q;
	logic [9:0]          ier_q;
	logic                cmdWdEn_q;
	logic [PERIOD_W-1:0] cmdWdPeriod_q;
	logic                bpWdEn_q;
	logic [PERIOD_W-1:0] bpWdPeriod_q;
	logic                inPacket_q;
	logic [10:0]         expLen_q;
	logic [10:0]         argCount_q;
	logic [1:0]          cryptoSync;
	logic [9:0]          eventFlags;
	logic                wrWord;
	logic                wrFinal;
	logic                wrAccepted;
	logic                rdRsp;
	logic                lenBad;
	logic [10:0]         finalArgs;
	logic [10:0]         finalLen;
	logic                cmdExpire;
	logic                bpExpire;
	logic                cmdRun;
	logic                bpRun;

	////////////////////////////////////////////////////////////////////////////////
	// Decode helper, used for the write and response-read offset compares; the read port decodes with a case
	function automatic logic hit(input logic [3:0] addr, input logic [3:0] ofs);
		hit = (addr == ofs);
	endfunction

	assign wrWord     = ce && busWrite && hit(busAddr, `MST_OFS_CMD_WORD);
	assign wrFinal    = ce && busWrite && hit(busAddr, `MST_OFS_CMD_FINAL);
	assign wrAccepted = (wrWord || wrFinal) && !cmdFifoFull;
	assign rdRsp      = ce && busRead && hit(busAddr, `MST_OFS_RSP_DATA);

	////////////////////////////////////////////////////////////////////////////////
	// Crypto path levels come from the memory bus domain, so they are synchronised
	mst_sync2 #(
		.WIDTH (2)
	) u_cryptoSync (
		.sys_clk (sys_clk),
		.srst    (srst),
		.ce      (ce),
		.asyncIn ({cryptoRecoveryPin, cryptoMemTimeoutPin}),
		.syncOut (cryptoSync)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Header length compare at the final word; a lone final word is its own header
	assign finalArgs = inPacket_q ? 11'(argCount_q + 1'b1) : 11'h000;
	assign finalLen  = inPacket_q ? expLen_q : busWriteData[`MST_HDR_LEN_MSB:`MST_HDR_LEN_LSB];
	assign lenBad    = wrFinal && !cmdFifoFull && (finalArgs != finalLen);

	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			inPacket_q <= 1'b0;
			expLen_q   <= 11'h000;
			argCount_q <= 11'h000;
		end
		else if (wrWord && !cmdFifoFull)
		begin
			if (!inPacket_q)
			begin
				inPacket_q <= 1'b1;
				expLen_q   <= busWriteData[`MST_HDR_LEN_MSB:`MST_HDR_LEN_LSB];
				argCount_q <= 11'h000;
			end
			else
			begin
				argCount_q <= argCount_q + 1'b1;
			end
		end
		else if (wrFinal && !cmdFifoFull)
		begin
			inPacket_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Watchdogs: command timer arms on a word write, backpressure timer on ready low
	mst_watchdog #(
		.PERIOD_W (PERIOD_W)
	) u_cmdWd (
		.sys_clk (sys_clk),
		.srst    (srst),
		.ce      (ce),
		.enable  (cmdWdEn_q),
		.period  (cmdWdPeriod_q),
		.start   (wrWord && !cmdFifoFull),
		.stop    (wrFinal && !cmdFifoFull),
		.running (cmdRun),
		.expire  (cmdExpire)
	);

	mst_watchdog #(
		.PERIOD_W (PERIOD_W)
	) u_bpWd (
		.sys_clk (sys_clk),
		.srst    (srst),
		.ce      (ce),
		.enable  (bpWdEn_q),
		.period  (bpWdPeriod_q),
		.start   (!mgrReady),
		.stop    (mgrReady),
		.running (bpRun),
		.expire  (bpExpire)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Timer registers; expiry clears the enable even if software writes the same cycle
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			cmdWdEn_q     <= 1'b0;
			cmdWdPeriod_q <= PERIOD_W'(`MST_WD_RESET_VALUE);
			bpWdEn_q      <= 1'b0;
			bpWdPeriod_q  <= PERIOD_W'(`MST_WD_RESET_VALUE);
		end
		else if (ce)
		begin
			if (busWrite && hit(busAddr, `MST_OFS_CMD_WATCHDOG))
			begin
				cmdWdEn_q     <= busWriteData[`MST_WD_EN_BIT];
				cmdWdPeriod_q <= busWriteData[PERIOD_W-1:0];
			end
			if (cmdExpire)
			begin
				cmdWdEn_q <= 1'b0;
			end
			if (busWrite && hit(busAddr, `MST_OFS_BP_WATCHDOG))
			begin
				bpWdEn_q     <= busWriteData[`MST_WD_EN_BIT];
				bpWdPeriod_q <= busWriteData[PERIOD_W-1:0];
			end
			if (bpExpire)
			begin
				bpWdEn_q <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Sticky error flags; only reset clears them, so the memory timeout flag re-raises
	// after reset if the crypto memory timeout pin stays high
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			sticky_q <= 10'h000;
		end
		else if (ce)
		begin
			if (rdRsp && rspFifoEmpty)
			begin
				sticky_q[`MST_EV_EMPTY_READ] <= 1'b1;
			end
			if ((wrWord || wrFinal) && cmdFifoFull)
			begin
				sticky_q[`MST_EV_FULL_WRITE] <= 1'b1;
			end
			if (cryptoSync[0])
			begin
				sticky_q[`MST_EV_MEM_TIMEOUT] <= 1'b1;
			end
			if (bpExpire)
			begin
				sticky_q[`MST_EV_BP_TIMEOUT] <= 1'b1;
			end
			if (cmdExpire)
			begin
				sticky_q[`MST_EV_EOP_TIMEOUT] <= 1'b1;
			end
			if (lenBad)
			begin
				sticky_q[`MST_EV_LEN_MISMATCH] <= 1'b1;
			end
		end
	end

	// Live bits follow the FIFOs and the recovery level; all bits visible regardless of enables
	always_comb
	begin
		eventFlags                      = sticky_q & `MST_EV_ERROR_MASK;
		eventFlags[`MST_EV_RECOVERY]    = cryptoSync[1];
		eventFlags[`MST_EV_CMD_NOT_FULL] = !cmdFifoFull;
		eventFlags[`MST_EV_DATA_VALID]  = !rspFifoEmpty;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Interrupt enables and the gated interrupt output
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			ier_q <= 10'h000;
			irq   <= 1'b0;
		end
		else if (ce)
		begin
			if (busWrite && hit(busAddr, `MST_OFS_IRQ_ENABLE))
			begin
				ier_q <= busWriteData[9:0] & `MST_EV_USED_MASK;
			end
			irq <= |(eventFlags & ier_q);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Command FIFO push; a write to a full FIFO is dropped, never pushed
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			cmdPush <= 1'b0;
			cmdWord <= '0;
			cmdLast <= 1'b0;
		end
		else if (ce)
		begin
			cmdPush <= wrAccepted;
			cmdLast <= wrFinal;
			if (wrAccepted)
			begin
				cmdWord <= busWriteData;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Response side: any error holds the flush until reset, so no later response escapes
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			rspFlush <= 1'b0;
			rspPop   <= 1'b0;
		end
		else if (ce)
		begin
			rspFlush <= rspFlush || (|(eventFlags & `MST_EV_ERROR_MASK));
			rspPop   <= rdRsp && !rspFifoEmpty && !rspFlush;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read port: data one cycle after the read; unmapped and write-only offsets read zero
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			busReadData  <= '0;
			busReadValid <= 1'b0;
		end
		else if (ce)
		begin
			busReadValid <= busRead;
			busReadData  <= '0;
			if (busRead)
			begin
				case (busAddr)
					`MST_OFS_CMD_SPACE:    busReadData <= 32'(cmdFifoSpace);
					`MST_OFS_RSP_DATA:     busReadData <= (rspFifoEmpty || rspFlush) ? 32'h0000_0000 : rspData;
					`MST_OFS_RSP_LEVEL:    busReadData <= {30'(rspFifoLevel), rspEop, rspSop};
					`MST_OFS_IRQ_ENABLE:   busReadData <= 32'(ier_q);
					`MST_OFS_EVENT_FLAGS:  busReadData <= 32'(eventFlags);
					`MST_OFS_CMD_WATCHDOG: busReadData <= {cmdWdEn_q, cmdWdPeriod_q};
					`MST_OFS_BP_WATCHDOG:  busReadData <= {bpWdEn_q, bpWdPeriod_q};
					default:               busReadData <= 32'h0000_0000;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks on the flags, timers and response flush
	property p_emptyRead;
		@(posedge sys_clk) disable iff (srst)
		rdRsp && rspFifoEmpty |=> sticky_q[`MST_EV_EMPTY_READ] && !rspPop;
	endproperty
	a_emptyRead: assert property (p_emptyRead) else $error("empty read flag not set");

	property p_fullWrite;
		@(posedge sys_clk) disable iff (srst)
		(wrWord || wrFinal) && cmdFifoFull |=> sticky_q[`MST_EV_FULL_WRITE] && !cmdPush;
	endproperty
	a_fullWrite: assert property (p_fullWrite) else $error("full write flag or drop wrong");

	property p_flush;
		@(posedge sys_clk) disable iff (srst)
		ce && (|(sticky_q & `MST_EV_ERROR_MASK)) |=> rspFlush [*3];
	endproperty
	a_flush: assert property (p_flush) else $error("responses not flushed after error");

	property p_recovery;
		@(posedge sys_clk) disable iff (srst)
		ce ##1 ce |=> eventFlags[`MST_EV_RECOVERY] == $past(cryptoRecoveryPin, 2);
	endproperty
	a_recovery: assert property (p_recovery) else $error("recovery flag does not track pin");

	property p_cmdExpire;
		@(posedge sys_clk) disable iff (srst)
		cmdExpire |=> sticky_q[`MST_EV_EOP_TIMEOUT] && !cmdWdEn_q && !cmdRun;
	endproperty
	a_cmdExpire: assert property (p_cmdExpire) else $error("command expiry effects missing");

	property p_bpExpire;
		@(posedge sys_clk) disable iff (srst)
		bpExpire |=> sticky_q[`MST_EV_BP_TIMEOUT] && !bpWdEn_q && !bpRun;
	endproperty
	a_bpExpire: assert property (p_bpExpire) else $error("backpressure expiry effects missing");

	property p_finalStops;
		@(posedge sys_clk) disable iff (srst)
		wrFinal && !cmdFifoFull |=> !cmdRun && !sticky_q[`MST_EV_EOP_TIMEOUT] || $past(sticky_q[`MST_EV_EOP_TIMEOUT]);
	endproperty
	a_finalStops: assert property (p_finalStops) else $error("command timer kept running");

	property p_resetDefaults;
		@(posedge sys_clk) disable iff (srst)
		$past(srst) |-> sticky_q == 10'h000 && !cmdWdEn_q && !bpWdEn_q
			&& cmdWdPeriod_q == PERIOD_W'(`MST_WD_RESET_VALUE) && bpWdPeriod_q == PERIOD_W'(`MST_WD_RESET_VALUE);
	endproperty
	a_resetDefaults: assert property (p_resetDefaults) else $error("reset values wrong");

	property p_irq;
		@(posedge sys_clk) disable iff (srst)
		ce |=> irq == $past(|(eventFlags & ier_q));
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt not gated by enables");

	property p_lenBad;
		@(posedge sys_clk) disable iff (srst)
		lenBad |=> sticky_q[`MST_EV_LEN_MISMATCH] ##1 rspFlush;
	endproperty
	a_lenBad: assert property (p_lenBad) else $error("length mismatch not flagged");

endmodule

// [verif/mst_far_model.sv]
// Far-side model: command FIFO fill, response FIFO contents and manager ready
`timescale 1ns/10ps
module mst_far_model
	import mst_pkg::*;
#(
	parameter int DEPTH   = 4,
	parameter int LEVEL_W = 11
) (
	input  wire logic          sys_clk,
	input  wire logic          srst,
	input  wire logic          cmdPush,
	input  wire logic          rspPop,
	input  wire logic          rspFlush,
	input  wire logic          stall,
	input  wire logic          rspAdd,
	output logic               cmdFifoFull,
	output logic [LEVEL_W-1:0] cmdFifoSpace,
	output logic               rspFifoEmpty,
	output logic [LEVEL_W-1:0] rspFifoLevel,
	output mst_word_t          rspData,
	output logic               mgrReady
);
	logic [LEVEL_W-1:0] cmdCount_q;
	logic [LEVEL_W-1:0] rspCount_q;
	logic               toggle_q;

	////////////////////////////////////////////////////////////////////////////////
	// Command side never drains, so a few pushes are enough to reach full
	always_ff @(posedge sys_clk)
	begin
		if (srst)
			cmdCount_q <= '0;
		else if (cmdPush)
			cmdCount_q <= cmdCount_q + 1'b1;
	end

	// Response side: loaded by the bench, popped by the block, emptied by a flush
	// Loading wins over the flush so the bench can show a valid head while flushed
	always_ff @(posedge sys_clk)
	begin
		if (srst)
			rspCount_q <= '0;
		else if (rspAdd)
			rspCount_q <= rspCount_q + 1'b1;
		else if (rspFlush)
			rspCount_q <= '0;
		else if (rspPop && rspCount_q != '0)
			rspCount_q <= rspCount_q - 1'b1;
	end

	// Toggles every cycle so an empty head never looks like stale data
	always_ff @(posedge sys_clk)
	begin
		if (srst)
			toggle_q <= 1'b0;
		else
			toggle_q <= !toggle_q;
	end

	// Head word carries the fill level so the bench can predict it
	assign cmdFifoFull  = (cmdCount_q == LEVEL_W'(DEPTH));
	assign cmdFifoSpace = LEVEL_W'(DEPTH) - cmdCount_q;
	assign rspFifoEmpty = (rspCount_q == '0);
	assign rspFifoLevel = rspCount_q;
	assign rspData      = rspFifoEmpty ? {32{toggle_q}} : 32'hd000_0000 + 32'(rspCount_q);
	assign mgrReady     = !stall;
endmodule

// [verif/mst_status_timers_tb_top.sv]
// Self-checking bench of the mailbox status flags and watchdogs
`timescale 1ns/10ps
module mst_status_timers_tb_top
	import mst_pkg::*;
;

	typedef struct {logic [3:0] addr; mst_word_t exp;} mst_tb_row_s;

	logic        sys_clk = 1'b0;
	logic        srst = 1'b1;
	logic        ce = 1'b1;
	logic [3:0]  busAddr = 4'h0;
	logic        busWrite = 1'b0;
	logic        busRead = 1'b0;
	mst_word_t   busWriteData = 32'h0;
	mst_word_t   busReadData, rspData, cmdWord, v;
	logic        busReadValid, cmdFifoFull, rspFifoEmpty, rspSop, rspEop, mgrReady;
	logic        cmdPush, cmdLast, rspPop, rspFlush, irq;
	logic        stall = 1'b0;
	logic        rspAdd = 1'b0;
	logic        memTimeout = 1'b0;
	logic        recovery = 1'b0;
	logic        pushSeen, lastSeen, popSeen;
	logic [10:0] cmdFifoSpace, rspFifoLevel;
	int          failCount = 0;
	int          numChecks = 0;
	mst_tb_row_s rows [8] = '{'{4'h8, 32'h2}, '{4'h9, 32'h07ff_ffff}, '{4'ha, 32'h07ff_ffff},
		'{4'h7, 32'h0}, '{4'h3, 32'h0}, '{4'h0, 32'h0}, '{4'h2, 32'h4}, '{4'h6, 32'h1}};

	assign rspSop = 1'b1;
	assign rspEop = 1'b0;

	always #5 sys_clk = !sys_clk;

	mst_status_timers i_dut (.sys_clk(sys_clk), .srst(srst), .ce(ce), .busAddr(busAddr),
		.busWrite(busWrite), .busRead(busRead), .busWriteData(busWriteData), .busReadData(busReadData),
		.busReadValid(busReadValid), .cmdFifoFull(cmdFifoFull), .cmdFifoSpace(cmdFifoSpace),
		.rspFifoEmpty(rspFifoEmpty), .rspFifoLevel(rspFifoLevel), .rspSop(rspSop), .rspEop(rspEop),
		.rspData(rspData), .mgrReady(mgrReady), .cryptoMemTimeoutPin(memTimeout),
		.cryptoRecoveryPin(recovery), .cmdPush(cmdPush), .cmdWord(cmdWord), .cmdLast(cmdLast),
		.rspPop(rspPop), .rspFlush(rspFlush), .irq(irq));

	mst_far_model i_far (.sys_clk(sys_clk), .srst(srst), .cmdPush(cmdPush), .rspPop(rspPop),
		.rspFlush(rspFlush), .stall(stall), .rspAdd(rspAdd), .cmdFifoFull(cmdFifoFull),
		.cmdFifoSpace(cmdFifoSpace), .rspFifoEmpty(rspFifoEmpty), .rspFifoLevel(rspFifoLevel),
		.rspData(rspData), .mgrReady(mgrReady));

	////////////////////////////////////////////////////////////////////////////////
	// Every task called from the main sequence after the first reset starts and ends 1 ns after a rising edge
	task automatic chk(input string name, input mst_word_t exp, input mst_word_t got);
		numChecks++;
		if (got !== exp)
		begin
			failCount++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	// Reset is synchronous, so it is held over whole edges
	task automatic doReset(input int n);
		srst = 1'b1;
		idle(n);
		srst = 1'b0;
	endtask

	// A spare edge after each access, so a following call never re-raises a strobe in the same step
	task automatic wr(input logic [3:0] a, input mst_word_t d);
		busAddr = a;
		busWriteData = d;
		busWrite = 1'b1;
		idle(1);
		busWrite = 1'b0;
		pushSeen = cmdPush;
		lastSeen = cmdLast;
		idle(1);
	endtask

	// Answer is registered: it shows right after the edge that takes the read
	task automatic rd(input logic [3:0] a, output mst_word_t d);
		busAddr = a;
		busRead = 1'b1;
		idle(1);
		busRead = 1'b0;
		chk("read valid", 32'h1, {31'h0, busReadValid});
		d = busReadData;
		popSeen = rspPop;
		idle(1);
	endtask

	task automatic end_of_test;
		$display("Checks made %0d, mismatches %0d", numChecks, failCount);
		if (failCount == 0 && numChecks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Watchdog: the whole run needs well under a thousand cycles
	initial
	begin
		#20000;
		failCount++;
		end_of_test();
	end

	// Main sequence: table of reset values first, then hand-written cases
	initial
	begin
		doReset(4);
		foreach (rows[i])
		begin
			rd(rows[i].addr, v);
			chk("reset row", rows[i].exp, v);
		end
		$display("test reset values done");
		wr(4'h9, 32'h8000_0005);
		wr(4'h0, 32'h0000_1000);
		wr(4'h1, 32'h1234_5678);
		chk("final word pushed", 32'h3, {30'h0, pushSeen, lastSeen});
		chk("final word value", 32'h1234_5678, cmdWord);
		idle(10);
		rd(4'h8, v);
		chk("complete command flags", 32'h2, v);
		rd(4'h9, v);
		chk("command timer kept", 32'h8000_0005, v);
		wr(4'h7, 32'h2);
		idle(1);
		chk("irq enabled", 32'h1, {31'h0, irq});
		wr(4'h7, 32'h0);
		idle(1);
		chk("irq masked", 32'h0, {31'h0, irq});
		$display("test good command done");
		rspAdd = 1'b1;
		idle(2);
		rspAdd = 1'b0;
		rd(4'h8, v);
		chk("data valid flag", 32'h3, v);
		rd(4'h5, v);
		chk("first response", 32'hd000_0002, v);
		chk("first pop", 32'h1, {31'h0, popSeen});
		idle(1);
		rd(4'h5, v);
		chk("second response", 32'hd000_0001, v);
		idle(1);
		rd(4'h8, v);
		chk("drained flags", 32'h2, v);
		rd(4'h5, v);
		chk("empty read data", 32'h0, v);
		idle(2);
		rd(4'h8, v);
		chk("empty read flag", 32'h202, v);
		chk("flush level", 32'h1, {31'h0, rspFlush});
		// Keep loading so the head is valid while flushed; only the block's gating can hide it
		rspAdd = 1'b1;
		idle(1);
		rd(4'h5, v);
		rspAdd = 1'b0;
		chk("response after error", 32'h0, v);
		chk("no pop after error", 32'h0, {31'h0, popSeen});
		$display("test responses done");
		doReset(10);
		rd(4'h8, v);
		chk("flags cleared", 32'h2, v);
		wr(4'h0, 32'h0000_2000);
		wr(4'h1, 32'h0000_0001);
		idle(2);
		rd(4'h8, v);
		chk("length mismatch", 32'ha, v);
		$display("test length mismatch done");
		doReset(10);
		wr(4'h9, 32'h8000_0005);
		wr(4'h0, 32'h0000_1000);
		idle(10);
		rd(4'h8, v);
		chk("end of packet timeout", 32'h12, v);
		rd(4'h9, v);
		chk("command timer disabled", 32'h0000_0005, v);
		$display("test command timeout done");
		doReset(10);
		wr(4'ha, 32'h8000_0005);
		stall = 1'b1;
		idle(10);
		stall = 1'b0;
		rd(4'h8, v);
		chk("backpressure timeout", 32'h22, v);
		rd(4'ha, v);
		chk("backpressure timer disabled", 32'h0000_0005, v);
		doReset(10);
		rd(4'ha, v);
		chk("backpressure timer default", 32'h07ff_ffff, v);
		$display("test backpressure done");
		repeat (4) wr(4'h0, 32'h0000_4000);
		rd(4'h8, v);
		chk("full flags", 32'h0, v);
		wr(4'h0, 32'h0000_0001);
		idle(1);
		chk("dropped push", 32'h0, {30'h0, pushSeen, lastSeen});
		rd(4'h8, v);
		chk("full write flag", 32'h100, v);
		$display("test full write done");
		doReset(10);
		memTimeout = 1'b1;
		idle(4);
		rd(4'h8, v);
		chk("memory timeout", 32'h42, v);
		memTimeout = 1'b0;
		doReset(10);
		recovery = 1'b1;
		idle(4);
		rd(4'h8, v);
		chk("recovery running", 32'h82, v);
		wr(4'h7, 32'h80);
		idle(1);
		chk("recovery irq", 32'h1, {31'h0, irq});
		recovery = 1'b0;
		idle(4);
		rd(4'h8, v);
		chk("recovery done", 32'h2, v);
		$display("test crypto flags done");
		// Writes while the clock enable is low must leave no trace
		ce = 1'b0;
		wr(4'h9, 32'h8000_0003);
		ce = 1'b1;
		rd(4'h9, v);
		chk("frozen write", 32'h07ff_ffff, v);
		$display("test clock enable done");
		end_of_test();
	end
endmodule
